// ### rtl/tocmp_channel.v
// One compare channel: value, inhibit after high-byte write, match detect, pin latch
`timescale 1ns/1ns
`include "tocmp_consts.vh"

module tocmp_channel (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        tick,
    input  wire [15:0] counter,
    input  wire        wr_high,
    input  wire        wr_low,
    input  wire [7:0]  wdata,
    input  wire        level,
    output reg  [15:0] value,
    output wire        match,
    output reg         pin_latch
);

    reg inhibit;

    // Exact 16-bit equality, once per timer clock
    assign match = tick & ~inhibit & (value == counter);

    always @(posedge aclk) begin
        if (!aresetn) begin
            value     <= `TOCMP_CMP_RESET;
            inhibit   <= 1'b0;
            pin_latch <= 1'b0;
        end else begin
            // Only software writes change the value
            if (wr_high) begin
                value[15:8] <= wdata;
                inhibit     <= 1'b1;
            end
            if (wr_low) begin
                value[7:0] <= wdata;
                inhibit    <= 1'b0;
            end
            if (match) begin
                pin_latch <= level;
            end
        end
    end

endmodule

// ### rtl/tocmp_consts.vh
// Constants of the timer output compare block: offsets, fields, reset values
`ifndef TOCMP_CONSTS_VH
`define TOCMP_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TOCMP_OFF_CTRL_ONE   8'h00
`define TOCMP_OFF_CTRL_TWO   8'h04
`define TOCMP_OFF_STATUS     8'h08
`define TOCMP_OFF_C1_HIGH    8'h0C
`define TOCMP_OFF_C1_LOW     8'h10
`define TOCMP_OFF_C2_HIGH    8'h14
`define TOCMP_OFF_C2_LOW     8'h18
`define TOCMP_OFF_COUNTER    8'h1C
`define TOCMP_OFF_IRQ_STAT   8'h20
`define TOCMP_OFF_IRQ_MASK   8'h24

// ----------------------------------------
// Fields
// ----------------------------------------
// Control one: bit0 irq enable, bit1 level ch1, bit2 level ch2
`define TOCMP_C1_IRQ_EN      0
`define TOCMP_C1_LVL1        1
`define TOCMP_C1_LVL2        2
// Control two: bit0 pin enable ch1, bit1 pin enable ch2, bits3:2 clock select
`define TOCMP_C2_PEN1        0
`define TOCMP_C2_PEN2        1
`define TOCMP_C2_CS_LO       2
`define TOCMP_C2_CS_HI       3
// Clock select codes
`define TOCMP_CS_DIV4        2'b00
`define TOCMP_CS_DIV2        2'b01
`define TOCMP_CS_DIV8        2'b10
`define TOCMP_CS_EXT         2'b11

// ----------------------------------------
// Reset values and AXI answers
// ----------------------------------------
`define TOCMP_CMP_RESET      16'h8000
`define TOCMP_CTRL_RESET     8'h00
`define TOCMP_RESP_OKAY      2'b00
`define TOCMP_RESP_SLVERR    2'b10

`endif

// ### rtl/tocmp_prescaler.v
// Timer tick generator: CPU clock divided by 2, 4 or 8, or external clock edges
`timescale 1ns/1ns
`include "tocmp_consts.vh"

module tocmp_prescaler (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [1:0] clock_select,
    input  wire       ext_timer_clk,
    output reg        tick
);

    reg [2:0] div_count;
    reg       ext_sync1;
    reg       ext_sync2;
    reg       ext_prev;
    reg       next_tick;

    always @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= 3'h0;
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev  <= 1'b0;
            tick      <= 1'b0;
        end else begin
            div_count <= div_count + 3'h1;
            ext_sync1 <= ext_timer_clk;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
            tick      <= next_tick;
        end
    end

    // One tick per counter increment
    always @* begin
        case (clock_select)
            `TOCMP_CS_DIV2: next_tick = (div_count[0] == 1'b1);
            `TOCMP_CS_DIV4: next_tick = (div_count[1:0] == 2'b11);
            `TOCMP_CS_DIV8: next_tick = (div_count == 3'h7);
            `TOCMP_CS_EXT:  next_tick = ext_sync2 & ~ext_prev;
            default:        next_tick = 1'b0;
        endcase
    end

endmodule

// ### rtl/tocmp_top.v
// Timer output compare block with AXI4-Lite register slave
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tocmp_consts.vh"

module tocmp_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        ext_timer_clk,
    input  wire        global_irq_mask,
    input  wire [1:0]  port_out_data,
    output wire [1:0]  compare_output_pin,
    output wire        timer_irq,
    output wire        irq
);

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    reg  [7:0]  timer_control_one;
    reg  [7:0]  timer_control_two;
    reg  [1:0]  compare_match_flag;
    reg  [1:0]  flag_armed;
    reg  [15:0] free_counter;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_mask;
    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;

    wire        tick;
    wire [15:0] compare_one_value;
    wire [15:0] compare_two_value;
    wire [1:0]  match;
    wire [1:0]  pin_latch;
    wire        timer_irq_enable;
    wire [1:0]  compare_output_level;
    wire [1:0]  compare_pin_enable;
    wire [1:0]  timer_clock_select;

    assign timer_irq_enable        = timer_control_one[`TOCMP_C1_IRQ_EN];
    assign compare_output_level[0] = timer_control_one[`TOCMP_C1_LVL1];
    assign compare_output_level[1] = timer_control_one[`TOCMP_C1_LVL2];
    assign compare_pin_enable[0]   = timer_control_two[`TOCMP_C2_PEN1];
    assign compare_pin_enable[1]   = timer_control_two[`TOCMP_C2_PEN2];
    assign timer_clock_select      = timer_control_two[`TOCMP_C2_CS_HI:`TOCMP_C2_CS_LO];

    // ----------------------------------------
    // AXI write path
    // ----------------------------------------
    // Address and data are latched separately so either may come first
    // Only lane 0 carries register bits; a write without it changes nothing but still answers
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire wr_lane = w_strb[0];

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    function is_mapped;
        input [7:0] a;
        begin
            case (a)
                `TOCMP_OFF_CTRL_ONE, `TOCMP_OFF_CTRL_TWO, `TOCMP_OFF_STATUS,
                `TOCMP_OFF_C1_HIGH, `TOCMP_OFF_C1_LOW, `TOCMP_OFF_C2_HIGH,
                `TOCMP_OFF_C2_LOW, `TOCMP_OFF_COUNTER, `TOCMP_OFF_IRQ_STAT,
                `TOCMP_OFF_IRQ_MASK: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // Byte-wide registers read back in the low lane of the data word
    function [31:0] pad_byte;
        input [7:0] b;
        begin
            pad_byte = {24'h00_0000, b};
        end
    endfunction

    wire wr_c1_high = wr_go & wr_lane & (aw_addr == `TOCMP_OFF_C1_HIGH);
    wire wr_c1_low  = wr_go & wr_lane & (aw_addr == `TOCMP_OFF_C1_LOW);
    wire wr_c2_high = wr_go & wr_lane & (aw_addr == `TOCMP_OFF_C2_HIGH);
    wire wr_c2_low  = wr_go & wr_lane & (aw_addr == `TOCMP_OFF_C2_LOW);

    // Any access to a low byte, read or write, drops the arming; a write or an armed read finishes the flag clear
    wire [1:0] low_access;
    assign low_access[0] = wr_c1_low | (rd_go & (s_axi_araddr == `TOCMP_OFF_C1_LOW));
    assign low_access[1] = wr_c2_low | (rd_go & (s_axi_araddr == `TOCMP_OFF_C2_LOW));
    wire rd_status   = rd_go & (s_axi_araddr == `TOCMP_OFF_STATUS);
    wire rd_irq_stat = rd_go & (s_axi_araddr == `TOCMP_OFF_IRQ_STAT);

    // A low-byte write always clears; a low-byte read clears only after an armed status read
    wire [1:0] low_write;
    wire [1:0] flag_clear;
    assign low_write[0]  = wr_c1_low;
    assign low_write[1]  = wr_c2_low;
    assign flag_clear[0] = low_write[0] | (low_access[0] & flag_armed[0]);
    assign flag_clear[1] = low_write[1] | (low_access[1] & flag_armed[1]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held           <= 1'b0;
            aw_addr           <= 8'h00;
            w_held            <= 1'b0;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `TOCMP_RESP_OKAY;
            timer_control_one <= `TOCMP_CTRL_RESET;
            timer_control_two <= `TOCMP_CTRL_RESET;
            irq_mask          <= 2'b00;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr) ? `TOCMP_RESP_OKAY : `TOCMP_RESP_SLVERR;
                if (wr_lane) begin
                    case (aw_addr)
                        `TOCMP_OFF_CTRL_ONE: timer_control_one <= w_data[7:0];
                        `TOCMP_OFF_CTRL_TWO: timer_control_two <= w_data[7:0];
                        `TOCMP_OFF_IRQ_MASK: irq_mask          <= w_data[1:0];
                        default: ;
                    endcase
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI read path
    // ----------------------------------------
    // Read side effects (arming, low-byte clear, irq status clear) act on the accepting edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TOCMP_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? `TOCMP_RESP_OKAY : `TOCMP_RESP_SLVERR;
            case (s_axi_araddr)
                `TOCMP_OFF_CTRL_ONE: s_axi_rdata <= pad_byte(timer_control_one);
                `TOCMP_OFF_CTRL_TWO: s_axi_rdata <= pad_byte(timer_control_two);
                `TOCMP_OFF_STATUS:   s_axi_rdata <= {30'h0000_0000, compare_match_flag};
                `TOCMP_OFF_C1_HIGH:  s_axi_rdata <= pad_byte(compare_one_value[15:8]);
                `TOCMP_OFF_C1_LOW:   s_axi_rdata <= pad_byte(compare_one_value[7:0]);
                `TOCMP_OFF_C2_HIGH:  s_axi_rdata <= pad_byte(compare_two_value[15:8]);
                `TOCMP_OFF_C2_LOW:   s_axi_rdata <= pad_byte(compare_two_value[7:0]);
                `TOCMP_OFF_COUNTER:  s_axi_rdata <= {16'h0000, free_counter};
                `TOCMP_OFF_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_status};
                `TOCMP_OFF_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask};
                default:             s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Timer core
    // ----------------------------------------
    // Clock select is read live, so a new divider takes effect on the next prescaler count
    // The tick is one registered pulse, so the counter and both compares see the same edge
    tocmp_prescaler u_prescaler (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .clock_select  (timer_clock_select),
        .ext_timer_clk (ext_timer_clk),
        .tick          (tick)
    );

    // Wraps through zero; equality is all that is tested, so targets across the wrap still hit
    always @(posedge aclk) begin
        if (!aresetn) begin
            free_counter <= 16'h0000;
        end else if (tick) begin
            free_counter <= free_counter + 16'h0001;
        end
    end

    // Both channels share the tick and the counter, so their matches line up cycle for cycle
    tocmp_channel u_chan_one (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick),
        .counter   (free_counter),
        .wr_high   (wr_c1_high),
        .wr_low    (wr_c1_low),
        .wdata     (w_data[7:0]),
        .level     (compare_output_level[0]),
        .value     (compare_one_value),
        .match     (match[0]),
        .pin_latch (pin_latch[0])
    );

    tocmp_channel u_chan_two (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick),
        .counter   (free_counter),
        .wr_high   (wr_c2_high),
        .wr_low    (wr_c2_low),
        .wdata     (w_data[7:0]),
        .level     (compare_output_level[1]),
        .value     (compare_two_value),
        .match     (match[1]),
        .pin_latch (pin_latch[1])
    );

    // ----------------------------------------
    // Flags, clear sequence and interrupts
    // ----------------------------------------
    // A new match wins over a clear in the same cycle, so no event is lost
    // Arming needs the flag set at the status read itself, as software saw it
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_flag
            always @(posedge aclk) begin
                if (!aresetn) begin
                    compare_match_flag[ch] <= 1'b0;
                    flag_armed[ch]         <= 1'b0;
                    irq_status[ch]         <= 1'b0;
                end else begin
                    if (match[ch]) begin
                        compare_match_flag[ch] <= 1'b1;
                    end else if (flag_clear[ch]) begin
                        compare_match_flag[ch] <= 1'b0;
                    end
                    if (rd_status & compare_match_flag[ch]) begin
                        flag_armed[ch] <= 1'b1;
                    end else if (low_access[ch]) begin
                        flag_armed[ch] <= 1'b0;
                    end
                    if (match[ch]) begin
                        irq_status[ch] <= 1'b1;
                    end else if (rd_irq_stat) begin
                        irq_status[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Pins and interrupts
    // ----------------------------------------
    // Pin falls back to its port data when compare output is not enabled
    assign compare_output_pin[0] = compare_pin_enable[0] ? pin_latch[0] : port_out_data[0];
    assign compare_output_pin[1] = compare_pin_enable[1] ? pin_latch[1] : port_out_data[1];

    // Level request from the flags, gated by the enable bit and the global mask: it stays up until software clears them or a gate drops it
    assign timer_irq = timer_irq_enable & ~global_irq_mask & (|compare_match_flag);
    // Sticky status and mask pair, independent of the global mask
    assign irq       = |(irq_status & irq_mask);

endmodule

// ### test/test_timer_output_compare.sv
// Self-checking bench for the timer output compare block
`timescale 1ns/1ns
`include "tocmp_consts.vh"
module test_timer_output_compare;
    reg         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, gmask = 1'b0;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0] wdata = 32'h0000_0000, s, c0, c1;
    reg  [1:0]  pod = 2'b11, rsp;
    reg  [15:0] t;
    wire        awready, wready, bvalid, arready, rvalid, tirq, irq, ext;
    wire [1:0]  bresp, rresp, pin;
    wire [31:0] rdata;
    integer     fail_count = 0, n_tests = 0, cyc = 0, i, k, e;
    // Reset view of the map: address, data, response
    localparam [179:0] ROWS = {
        `TOCMP_OFF_CTRL_ONE, 8'h00, 2'b00, `TOCMP_OFF_CTRL_TWO, 8'h00, 2'b00, `TOCMP_OFF_STATUS, 8'h00, 2'b00,
        `TOCMP_OFF_C1_HIGH, 8'h80, 2'b00, `TOCMP_OFF_C1_LOW, 8'h00, 2'b00, `TOCMP_OFF_C2_HIGH, 8'h80, 2'b00,
        `TOCMP_OFF_C2_LOW, 8'h00, 2'b00, `TOCMP_OFF_IRQ_STAT, 8'h00, 2'b00, `TOCMP_OFF_IRQ_MASK, 8'h00, 2'b00,
        8'h28, 8'h00, `TOCMP_RESP_SLVERR};

    tocmp_ext_clock u_ext (.ext_clk(ext));
    tocmp_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ext_timer_clk(ext), .global_irq_mask(gmask),
        .port_out_data(pod), .compare_output_pin(pin), .timer_irq(tirq), .irq(irq));

    always #4 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Handshake lines are settled at the falling edge, so sampling there shows the next rising edge
    task wr(input [7:0] a, input [7:0] d);
        reg ga, gw, gb;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            gb = 1'b0;
            while (!gb) begin
                @(negedge aclk);
                ga = awready;
                gw = wready;
                gb = bvalid;
                rsp = bresp;
                @(posedge aclk);
                if (ga) awvalid <= 1'b0;
                if (gw) wvalid <= 1'b0;
            end
        end
    endtask

    task rd(input [7:0] a, output [31:0] d);
        reg ga, gr;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            gr = 1'b0;
            while (!gr) begin
                @(negedge aclk);
                ga = arready;
                gr = rvalid;
                d = rdata;
                rsp = rresp;
                @(posedge aclk);
                if (ga) arvalid <= 1'b0;
            end
        end
    endtask

    task walk_rows;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                rd(ROWS[i*18+10 +: 8], s);
                chk(s, {24'h0, ROWS[i*18+2 +: 8]});
                chk(rsp, ROWS[i*18 +: 2]);
            end
        end
    endtask

    // Target sits 64 ticks ahead, far enough to outlast the bus traffic
    task arm(input [7:0] hi, input [7:0] lo);
        begin
            rd(`TOCMP_OFF_COUNTER, c0);
            t = c0[15:0] + 16'h0040;
            wr(hi, t[15:8]);
            rd(`TOCMP_OFF_STATUS, s);
            wr(lo, t[7:0]);
        end
    endtask

    task settle;
        begin
            repeat (200) @(posedge aclk);
            @(negedge aclk);
        end
    endtask

    task conclude;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count = fail_count + 1;
        conclude;
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        walk_rows;
        wr(8'h28, 8'h55);
        chk(rsp, `TOCMP_RESP_SLVERR);
        // Selects 01, 00, 10, 11: divide by 2, 4, 8, then the external source
        for (i = 0; i < 4; i = i + 1) begin
            wr(`TOCMP_OFF_CTRL_TWO, {4'h0, i[1], ~(i[0] ^ i[1]), 2'b00});
            rd(`TOCMP_OFF_COUNTER, c0);
            k = cyc;
            repeat (300) @(posedge aclk);
            rd(`TOCMP_OFF_COUNTER, c1);
            e = (c1[15:0] - c0[15:0]) - (cyc - k) * 8 / ((i == 3) ? 74 : 16 << i);
            chk(e >= -2 && e <= 2, 1);
        end
        @(negedge aclk);
        chk(pin, 2'b11);
        wr(`TOCMP_OFF_CTRL_TWO, 8'h07);
        wr(`TOCMP_OFF_CTRL_ONE, 8'h07);
        @(negedge aclk);
        chk(pin, 2'b00);
        arm(`TOCMP_OFF_C1_HIGH, `TOCMP_OFF_C1_LOW);
        settle;
        chk(pin, 2'b01);
        chk(tirq, 1'b1);
        chk(irq, 1'b0);
        @(posedge aclk);
        gmask <= 1'b1;
        @(negedge aclk);
        chk(tirq, 1'b0);
        rd(`TOCMP_OFF_STATUS, s);
        chk(s, 32'h1);
        rd(`TOCMP_OFF_C1_HIGH, s);
        chk(s, {24'h0, t[15:8]});
        rd(`TOCMP_OFF_C1_LOW, s);
        chk(s, {24'h0, t[7:0]});
        rd(`TOCMP_OFF_STATUS, s);
        chk(s, 32'h0);
        wr(`TOCMP_OFF_IRQ_MASK, 8'h03);
        @(negedge aclk);
        chk(irq, 1'b1);
        rd(`TOCMP_OFF_IRQ_STAT, s);
        chk(s[0], 1'b1);
        @(negedge aclk);
        chk(irq, 1'b0);
        arm(`TOCMP_OFF_C2_HIGH, `TOCMP_OFF_C2_LOW);
        wr(`TOCMP_OFF_C2_HIGH, t[15:8]);
        settle;
        chk(pin[1], 1'b0);
        rd(`TOCMP_OFF_STATUS, s);
        chk(s[1], 1'b0);
        arm(`TOCMP_OFF_C2_HIGH, `TOCMP_OFF_C2_LOW);
        settle;
        chk(pin[1], 1'b1);
        wr(`TOCMP_OFF_C2_LOW, t[7:0]);
        rd(`TOCMP_OFF_STATUS, s);
        chk(s[1], 1'b0);
        // Channel two now drives low on its match, so the level bit is really followed
        wr(`TOCMP_OFF_CTRL_ONE, 8'h03);
        arm(`TOCMP_OFF_C2_HIGH, `TOCMP_OFF_C2_LOW);
        settle;
        chk(pin, 2'b01);
        // Latch one is high here; after reset the pins show port data, then low latches once enabled
        @(posedge aclk);
        pod <= 2'b10;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(pin, 2'b10);
        walk_rows;
        wr(`TOCMP_OFF_CTRL_TWO, 8'h03);
        @(negedge aclk);
        chk(pin, 2'b00);
        conclude;
    end
endmodule

// ### test/tocmp_ext_clock.sv
// Off-board timer clock source feeding the external clock input
`timescale 1ns/1ns
module tocmp_ext_clock (
    output reg ext_clk
);
    // 74 ns period keeps its edges drifting against the 8 ns bus clock
    initial ext_clk = 1'b0;
    always #37 ext_clk = ~ext_clk;
endmodule

// ### test/tocmp_top_asserts.sv
// Port-level checks of the timer output compare block
`timescale 1ns/1ns
module tocmp_top_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        global_irq_mask,
    input wire [1:0]  port_out_data,
    input wire [1:0]  compare_output_pin,
    input wire        timer_irq,
    input wire        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_IRQ_GATE: assert property (timer_irq |-> !global_irq_mask)
        else $error("timer irq raised while globally masked");
    // Reset itself is the cause here, so these two stay armed through it
    AST_RST_PIN: assert property (disable iff (1'b0) !aresetn |=> compare_output_pin == port_out_data)
        else $error("compare pin not released to port data in reset");
    AST_RST_IRQ: assert property (disable iff (1'b0) !aresetn |=> !timer_irq && !irq)
        else $error("interrupt active after reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##[0:1] s_axi_bvalid)
        else $error("write response late");
endmodule

bind tocmp_top tocmp_top_asserts u_asserts (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .global_irq_mask, .port_out_data,
    .compare_output_pin, .timer_irq, .irq
);
